/* File: core/dma_address_ready_cascade.sv */
// dma address assembly, ready control, read strobe delay and cascade release
// assumes the dma cores run on dma_clk from this block and the page values are held
// stable outside; bus outputs are released with active-low enables
`timescale 1ns/1ps

// Overview of operation
// R01: page bits drive A17-A23, plus local bit 16 on byte channels.
// R02: core gives middle address at start and on each block crossing.
// R03: blocks are 256 bytes on channels 0-3, 512 on channels 5-7.
// R04: middle address on data bus in the address state is latched here.
// R05: middle latch drives local bits 8-15 byte-wide, 9-16 word-wide.
// R06: core low byte drives local bits 0-7 byte-wide, 1-8 word-wide.
// R07: local bit 0 stays low for every word-wide transfer.
// R08: both dma cores take one shared ready signal.
// R09: every dma transfer gets exactly one forced wait state.
// R10: a slow device pulls iochrdy low before the second dma clock phase.
// R11: wait states continue while iochrdy stays low.
// R12: iochrdy rising too late costs one more wait before the final state.
// R13: delayed read strobe falls one dma clock after the core strobe.
// R14: delayed read strobe rises together with the core strobe.
// R15: software sets cascade mode; drq and dack wire to the outer master.
// R16: acknowledged cascade channel floats data, command and local address.
// R17: acknowledged cascade channel still drives its page on A17-A23; here only while master_n stays high.
// R18: outer master waits for dack then may pull master_n low.
// R19: address counting wraps inside the page, page bits never change.
// R20: the dma clock is the core clock divided by two.
module dma_address_ready_cascade import dma_glue_pkg::*; #(
    parameter int CHANNELS = NUM_CH,
    parameter int DEPTH    = TRACE_DEPTH
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    // dma core side
    output      logic                   dma_clk,
    input  wire logic [CH_W-1:0]        dma_channel,
    input  wire logic                   dma_ack_active,
    input  wire logic                   core_address_strobe,
    input  wire logic [BYTE_W-1:0]      core_data,
    input  wire logic [BYTE_W-1:0]      core_low_address,
    input  wire logic                   core_transfer_active,
    input  wire logic                   core_drives_bus,
    input  wire logic                   core_memr_n,
    output      logic                   core_ready,
    // page values and channel modes
    input  wire logic [CHANNELS*PAGE_W-1:0] page_values,
    input  wire logic [CHANNELS-1:0]    cascade_mode,
    // system bus
    input  wire logic                   iochrdy,
    input  wire logic                   master_n,
    output      logic [UPPER_W-1:0]     upper_address,
    output      logic                   upper_address_oe_n,
    output      logic [LOCAL_W-1:0]     local_address_bus,
    output      logic                   local_address_oe_n,
    output      logic                   data_bus_oe_n,
    output      logic                   command_oe_n,
    output      logic                   delayed_memory_read_strobe_n,
    // address trace stream
    output      logic                   trace_valid,
    input  wire logic                   trace_ready,
    output      logic [ADDR_W-1:0]      trace_address
);
    initial begin
        if (CHANNELS != NUM_CH || DEPTH < 2) begin
            $error("glue needs eight channels and a trace depth of at least 2");
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [PAGE_W-1:0] page_of(input logic [CHANNELS*PAGE_W-1:0] pv,
                                                  input logic [CH_W-1:0] ch);
        return pv[ch*PAGE_W +: PAGE_W];
    endfunction

    // the low and middle parts come straight from the core, so a core wrap
    // inside the page can never reach the page bits
    function automatic logic [LOCAL_W-1:0] local_of(input logic             wide,
                                                    input logic [PAGE_W-1:0] page,
                                                    input logic [BYTE_W-1:0] mid,
                                                    input logic [BYTE_W-1:0] low);
        if (wide) begin
            return {mid, low, 1'b0}; // R05 R06 R07 R19
        end
        return {page[0], mid, low}; // R01 R05 R06 R19
    endfunction

    // ----------------------------------------
    // dma clock
    // ----------------------------------------
    logic dma_phase;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            dma_phase <= 1'b0;
        end else begin
            dma_phase <= ~dma_phase; // R20
        end
    end

    assign dma_clk = dma_phase;

    // second phase of the dma clock is where ready is sampled
    wire sample_edge = dma_phase;

    // ----------------------------------------
    // middle address latch
    // ----------------------------------------
    logic [BYTE_W-1:0] mid_latch;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            mid_latch <= MID_RESET;
        end else if (core_address_strobe) begin
            mid_latch <= core_data; // R02 R04
        end
    end

    // ----------------------------------------
    // address assembly and bus release
    // ----------------------------------------
    wire [PAGE_W-1:0]  sel_page     = page_of(page_values, dma_channel);
    wire               wide_channel = dma_channel[WIDE_CH_BIT]; // R03
    wire               cascade_ack  = dma_ack_active & cascade_mode[dma_channel];
    wire               own_cycle    = dma_ack_active & ~cascade_ack;
    wire [BYTE_W-1:0]  mid_now      = core_address_strobe ? core_data : mid_latch;
    wire [LOCAL_W-1:0] next_local   = local_of(wide_channel, sel_page, mid_now,
                                               core_low_address);
    wire [ADDR_W-1:0]  full_address = {sel_page[PAGE_W-1:1], next_local};

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            upper_address      <= '0;
            upper_address_oe_n <= 1'b1;
            local_address_bus  <= LOCAL_RESET;
            local_address_oe_n <= 1'b1;
            data_bus_oe_n      <= 1'b1;
            command_oe_n       <= 1'b1;
        end else begin
            upper_address      <= sel_page[PAGE_W-1:1]; // R01 R17
            upper_address_oe_n <= ~(dma_ack_active & master_n); // R17 R18
            local_address_bus  <= next_local;
            local_address_oe_n <= ~own_cycle; // R16
            data_bus_oe_n      <= ~(own_cycle & core_drives_bus); // R16
            command_oe_n       <= ~own_cycle; // R16 R15
        end
    end

    // ----------------------------------------
    // trace fifo
    // ----------------------------------------
    addr_fifo_if #(.W(ADDR_W)) trace_if ();

    addr_trace_fifo #(
        .W     (ADDR_W),
        .DEPTH (DEPTH)
    ) u_trace (
        .core_clk (core_clk),
        .rstn     (rstn),
        .f        (trace_if.fifo)
    );

    assign trace_if.out_ready = trace_ready;
    assign trace_valid        = trace_if.out_valid;
    assign trace_address      = trace_if.out_data;

    // ----------------------------------------
    // ready control
    // ----------------------------------------
    wait_state_t wait_state;
    wait_state_t next_wait_state;

    // a full trace queue stretches the wait, so no transfer goes unlogged
    wire waiting     = (wait_state == W_FORCED) || (wait_state == W_EXTEND);
    wire finish_wait = waiting & sample_edge & iochrdy & trace_if.in_ready; // R10 R12

    assign trace_if.in_valid = finish_wait;
    assign trace_if.in_data  = full_address;

    always_comb begin
        next_wait_state = wait_state;
        case (wait_state)
            W_IDLE: begin
                if (core_transfer_active && !dma_phase) begin
                    next_wait_state = W_FORCED; // R09
                end
            end
            W_FORCED: begin
                if (finish_wait) begin
                    next_wait_state = W_DONE;
                end else if (sample_edge) begin
                    next_wait_state = W_EXTEND; // R11
                end
            end
            W_EXTEND: begin
                if (finish_wait) begin
                    next_wait_state = W_DONE; // R11 R12
                end
            end
            W_DONE: begin
                if (!core_transfer_active) begin
                    next_wait_state = W_IDLE;
                end
            end
            default: next_wait_state = W_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wait_state <= W_IDLE;
        end else begin
            wait_state <= next_wait_state;
        end
    end

    // one ready feeds both cores
    assign core_ready = (wait_state == W_DONE); // R08

    // ----------------------------------------
    // read strobe delay
    // ----------------------------------------
    logic [MEMR_DELAY_SYSCLKS-1:0] memr_low_hist;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            memr_low_hist <= '0;
        end else if (core_memr_n) begin
            memr_low_hist <= '0;
        end else begin
            memr_low_hist <= {memr_low_hist[MEMR_DELAY_SYSCLKS-2:0], 1'b1}; // R13
        end
    end

    // the rise passes straight through so the trailing edge is never late
    assign delayed_memory_read_strobe_n =
        core_memr_n | ~memr_low_hist[MEMR_DELAY_SYSCLKS-1]; // R13 R14

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence memr_fall_s;
        $fell(core_memr_n);
    endsequence

    sequence memr_held_s;
        memr_fall_s ##1 !core_memr_n [*2];
    endsequence

    // iochrdy still low at the sampling phase, rising only in the phase after it
    sequence late_ready_s;
        waiting && sample_edge && !iochrdy ##1 iochrdy;
    endsequence

    chk_dma_clk_toggle : assert property (@(posedge core_clk) disable iff (!rstn) // R20
        $past(rstn) |-> dma_clk != $past(dma_clk)) else $error("dma clock did not toggle");

    chk_mid_latch_capture : assert property (@(posedge core_clk) disable iff (!rstn) // R04
        core_address_strobe |=> mid_latch == $past(core_data))
        else $error("middle address not latched");

    chk_byte_page_bit : assert property (@(posedge core_clk) disable iff (!rstn) // R01
        !wide_channel |=> local_address_bus[LOCAL_W-1] == $past(sel_page[0]))
        else $error("page bit missing on local bit 16");

    chk_word_low_bit : assert property (@(posedge core_clk) disable iff (!rstn) // R07
        wide_channel |=> local_address_bus[0] == 1'b0
                         && local_address_bus[8:1] == $past(core_low_address))
        else $error("word transfer address misplaced");

    chk_forced_wait_min : assert property (@(posedge core_clk) disable iff (!rstn) // R09
        wait_state == W_IDLE && next_wait_state == W_FORCED |-> !core_ready [*2])
        else $error("forced wait state skipped");

    chk_extend_while_low : assert property (@(posedge core_clk) disable iff (!rstn) // R11
        waiting && sample_edge && !iochrdy |=> wait_state == W_EXTEND && !core_ready)
        else $error("wait not extended while iochrdy low");

    chk_late_ready_wait : assert property (@(posedge core_clk) disable iff (!rstn) // R12
        late_ready_s |=> !core_ready) else $error("late iochrdy rise not penalised");

    chk_ready_bounded : assert property (@(posedge core_clk) disable iff (!rstn) // R11
        waiting && sample_edge && iochrdy && trace_if.in_ready |=> core_ready)
        else $error("ready not given after iochrdy high");

    chk_memr_lag : assert property (@(posedge core_clk) disable iff (!rstn) // R13
        memr_fall_s |-> delayed_memory_read_strobe_n ##1 delayed_memory_read_strobe_n)
        else $error("delayed read strobe fell early");

    chk_memr_follow : assert property (@(posedge core_clk) disable iff (!rstn) // R13
        memr_held_s |-> !delayed_memory_read_strobe_n)
        else $error("delayed read strobe did not fall");

    chk_memr_rise : assert property (@(posedge core_clk) disable iff (!rstn) // R14
        $rose(core_memr_n) |-> delayed_memory_read_strobe_n)
        else $error("delayed read strobe rose late");

    chk_cascade_float : assert property (@(posedge core_clk) disable iff (!rstn) // R16
        cascade_ack |=> local_address_oe_n && data_bus_oe_n && command_oe_n)
        else $error("bus driven during cascade");

    chk_cascade_page : assert property (@(posedge core_clk) disable iff (!rstn) // R17
        cascade_ack && master_n |=> !upper_address_oe_n
                                    && upper_address == $past(sel_page[PAGE_W-1:1]))
        else $error("cascade page not driven");
endmodule

/* File: include/dma_glue_pkg.sv */
// constants shared by the dma address, ready and cascade glue
// assumes a single 20 MHz core clock and an 8-channel dma core pair
package dma_glue_pkg;
    // ----------------------------------------
    // clocking
    // ----------------------------------------
    localparam int SYSCLK_MHZ         = 20;
    localparam int DMA_CLK_DIVIDE     = 2;
    localparam int MEMR_DELAY_SYSCLKS = 1 * DMA_CLK_DIVIDE;
    localparam int FORCED_WAIT_STATES = 1;

    // ----------------------------------------
    // address layout
    // ----------------------------------------
    localparam int ADDR_W       = 24;
    localparam int LOCAL_W      = 17;
    localparam int UPPER_W      = 7;
    localparam int PAGE_W       = 8;
    localparam int BYTE_W       = 8;
    localparam int CH_W         = 3;
    localparam int NUM_CH       = 8;
    localparam int WIDE_CH_BIT  = 2;
    localparam int BLOCK_8_BYTES  = 256;
    localparam int BLOCK_16_BYTES = 512;

    // ----------------------------------------
    // reset values and trace depth
    // ----------------------------------------
    localparam logic [LOCAL_W-1:0] LOCAL_RESET = 17'h00000;
    localparam logic [BYTE_W-1:0]  MID_RESET   = 8'h00;
    localparam int TRACE_DEPTH = 32;

    typedef enum logic [1:0] {W_IDLE, W_FORCED, W_EXTEND, W_DONE} wait_state_t;
endpackage

/* File: include/addr_fifo_if.sv */
// carrier between the glue logic and its address trace fifo
// assumes both ends share core_clk
`timescale 1ns/1ps
interface addr_fifo_if #(parameter int W = 24) ();
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* File: core/addr_trace_fifo.sv */
// synchronous fifo with a registered output word
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module addr_trace_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // queue ports
    addr_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("fifo depth must be a power of two, at least 2");
        end
    end

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   fill;
    logic          out_valid;
    logic [W-1:0]  out_data;

    wire push = f.in_valid & f.in_ready;
    wire load = (fill != '0) & (~out_valid | f.out_ready);

    assign f.in_ready  = (fill != (AW+1)'(DEPTH));
    assign f.out_valid = out_valid;
    assign f.out_data  = out_data;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= f.in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(load);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fill <= '0;
        end else if (push && !load) begin
            fill <= fill + (AW+1)'(1);
        end else if (load && !push) begin
            fill <= fill - (AW+1)'(1);
        end
    end

    // output stage is a register so the memory read sits off the port path
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            out_valid <= 1'b0;
            out_data  <= '0;
        end else if (load) begin
            out_valid <= 1'b1;
            out_data  <= mem[rd_ptr];
        end else if (f.out_ready) begin
            out_valid <= 1'b0;
        end
    end

    chk_fifo_no_overrun : assert property (@(posedge core_clk) disable iff (!rstn)
        fill <= (AW+1)'(DEPTH)) else $error("fifo fill above depth");
endmodule

/* File: sim/bus_side_model.sv */
// far-side model: a slow bus device on iochrdy and an outer master on master_n
// assumes the bench sets hold_edges before each transfer and watches dack
`timescale 1ns/1ps
module bus_side_model (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // observed from the glue
    input  wire logic       transfer_active,
    input  wire logic       dack,
    // bench control
    input  wire logic [3:0] hold_edges,
    input  wire logic       want_bus,
    // bus lines
    output      logic       iochrdy,
    output      logic       master_n
);
    logic [3:0] cnt;

    // ---------------------------------------------
    // slow device
    // ---------------------------------------------
    // pulled low from the first edge of a transfer when hold_edges is above 1, so the forced wait sees it low
    always @(posedge core_clk) begin
        if (!rstn || !transfer_active) begin
            cnt     <= 4'h0;
            iochrdy <= 1'b1;
        end else begin
            cnt     <= cnt + 4'h1;
            iochrdy <= (cnt + 4'h1) >= hold_edges;
        end
    end

    // ---------------------------------------------
    // outer master
    // ---------------------------------------------
    // never takes the bus before its acknowledge is seen
    always @(posedge core_clk) begin
        master_n <= !(rstn && want_bus && dack);
    end
endmodule

/* File: sim/dma_address_ready_cascade_test.sv */
// self-checking bench for the dma address, ready and cascade glue
// assumes bus_side_model answers iochrdy and master_n; the bench plays the dma core
`timescale 1ns/1ps
module dma_address_ready_cascade_test import dma_glue_pkg::*;;
    logic                rstn, core_clk, dma_clk, dma_ack_active, core_address_strobe;
    logic                core_transfer_active, core_drives_bus, core_memr_n, core_ready;
    logic                iochrdy, master_n, want_bus, trace_ready, trace_valid;
    logic                upper_address_oe_n, local_address_oe_n, data_bus_oe_n, command_oe_n;
    logic                delayed_memory_read_strobe_n;
    logic [CH_W-1:0]     dma_channel;
    logic [BYTE_W-1:0]   core_data, core_low_address, cur_mid;
    logic [63:0]         page_values;
    logic [7:0]          cascade_mode;
    logic [3:0]          hold_edges;
    logic [UPPER_W-1:0]  upper_address;
    logic [LOCAL_W-1:0]  local_address_bus;
    logic [ADDR_W-1:0]   trace_address;
    logic [ADDR_W-1:0]   expect_q[$];
    int                  err_total = 0;
    int                  checked = 0;
    int                  cycles = 0;

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    dma_address_ready_cascade u_dma_address_ready_cascade (
        .core_clk, .rstn, .dma_clk, .dma_channel, .dma_ack_active, .core_address_strobe,
        .core_data, .core_low_address, .core_transfer_active, .core_drives_bus,
        .core_memr_n, .core_ready, .page_values, .cascade_mode, .iochrdy, .master_n,
        .upper_address, .upper_address_oe_n, .local_address_bus, .local_address_oe_n,
        .data_bus_oe_n, .command_oe_n, .delayed_memory_read_strobe_n, .trace_valid,
        .trace_ready, .trace_address
    );

    bus_side_model u_bus_side_model (
        .core_clk, .rstn, .transfer_active(core_transfer_active),
        .dack(dma_ack_active & cascade_mode[dma_channel]),
        .hold_edges, .want_bus, .iochrdy, .master_n
    );

    // ---------------------------------------------
    // shared helpers
    // ---------------------------------------------
    task automatic print_verdict();
        if (err_total == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    function automatic logic [23:0] word_of(input logic [CH_W-1:0] ch,
                                           input logic [7:0] mid, input logic [7:0] low);
        logic [7:0] pg;
        pg = page_values[ch*8 +: 8];
        word_of = {pg[7:1], ch[2] ? {mid, low, 1'b0} : {pg[0], mid, low}};
    endfunction

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic run_reset();
        logic prev;
        rstn = 1'b0;
        tick(10);
        check({upper_address_oe_n, local_address_oe_n, data_bus_oe_n, command_oe_n}, 4'hF);
        check({core_ready, trace_valid, dma_clk, delayed_memory_read_strobe_n}, 4'h1);
        check({upper_address, local_address_bus}, 24'h000000);
        rstn = 1'b1;
        repeat (4) begin
            prev = dma_clk;
            tick(1);
            check(dma_clk, !prev);
        end
    endtask

    // strobe the middle byte, then scramble the data bus so only the latch can answer
    task automatic run_address(input logic [CH_W-1:0] ch, input logic [7:0] mid,
                               input logic [7:0] low);
        logic [23:0] w;
        dma_channel = ch;
        core_address_strobe = 1'b1;
        core_data = mid;
        core_low_address = low;
        tick(1);
        core_address_strobe = 1'b0;
        core_data = ~mid;
        cur_mid = mid;
        tick(1);
        w = word_of(ch, mid, low);
        check(local_address_bus, w[16:0]);
        check(upper_address, w[23:17]);
        check({local_address_oe_n, command_oe_n, data_bus_oe_n, upper_address_oe_n}, 4'h0);
    endtask

    // lat 0 means the trace fifo is full: ready must hold off until one word is taken from it
    task automatic run_xfer(input logic [3:0] hold, input int lat);
        int n;
        hold_edges = hold;
        n = 0;
        while (dma_clk !== 1'b0 && n < 4) begin
            tick(1);
            n++;
        end
        core_transfer_active = 1'b1;
        expect_q.push_back(word_of(dma_channel, cur_mid, core_low_address));
        n = 0;
        // a full queue is relieved by one single taken word, so none leaves unchecked
        while (core_ready !== 1'b1 && n < 40) begin
            trace_ready = (lat == 0 && n == 20);
            if (trace_ready && trace_valid === 1'b1) check(trace_address, expect_q.pop_front());
            tick(1);
            n++;
        end
        trace_ready = 1'b0;
        check(n > 20, lat == 0);
        if (lat > 0) check(n, lat);
        core_transfer_active = 1'b0;
        tick(1);
        check(core_ready, 1'b0);
        tick(1);
    endtask

    task automatic drain();
        int n;
        trace_ready = 1'b1;
        n = 0;
        while (expect_q.size() > 0 && n < 200) begin
            if (trace_valid === 1'b1) check(trace_address, expect_q.pop_front());
            tick(1);
            n++;
        end
        check(expect_q.size(), 0);
        check(trace_valid, 1'b0);
    endtask

    task automatic run_strobe();
        core_memr_n = 1'b0;
        tick(1);
        check(delayed_memory_read_strobe_n, 1'b1);
        tick(1);
        check(delayed_memory_read_strobe_n, 1'b0);
        tick(1);
        check(delayed_memory_read_strobe_n, 1'b0);
        core_memr_n = 1'b1;
        #1;
        check(delayed_memory_read_strobe_n, 1'b1);
        tick(1);
    endtask

    task automatic run_cascade();
        dma_channel = 3'h3;
        cascade_mode = 8'h08;
        tick(2);
        check({local_address_oe_n, command_oe_n, data_bus_oe_n}, 3'h7);
        check({upper_address_oe_n, upper_address}, {1'b0, page_values[31:25]});
        want_bus = 1'b1;
        tick(3);
        check(upper_address_oe_n, 1'b1);
        want_bus = 1'b0;
        cascade_mode = 8'h00;
        tick(3);
        check(upper_address_oe_n, 1'b0);
    endtask

    // ---------------------------------------------
    // main sequence and hang guard
    // ---------------------------------------------
    initial begin
        rstn = 1'b0;
        dma_channel = 3'h0;
        dma_ack_active = 1'b0;
        core_address_strobe = 1'b0;
        core_data = 8'h00;
        core_low_address = 8'h00;
        core_transfer_active = 1'b0;
        core_drives_bus = 1'b0;
        core_memr_n = 1'b1;
        page_values = 64'hF1E2D3C4B5A69788;
        cascade_mode = 8'h00;
        hold_edges = 4'h0;
        want_bus = 1'b0;
        trace_ready = 1'b0;
        cur_mid = 8'h00;
        run_reset();
        dma_ack_active = 1'b1;
        core_drives_bus = 1'b1;
        run_address(3'h1, 8'h5A, 8'hC3);
        run_address(3'h5, 8'hA5, 8'h3C);
        run_address(3'h0, 8'hFF, 8'hFF);
        run_address(3'h7, 8'h00, 8'h01);
        run_xfer(4'h0, 2);
        run_xfer(4'h3, 4);
        run_xfer(4'h4, 6);
        drain();
        run_strobe();
        run_cascade();
        run_address(3'h1, 8'h81, 8'h00);
        trace_ready = 1'b0;
        // 32 queued words plus the output register fill it; the 34th must stall
        for (int i = 0; i < 34; i++) begin
            core_low_address = i[7:0];
            run_xfer(4'h0, (i < 33) ? 2 : 0);
        end
        drain();
        print_verdict();
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 3000) begin
            err_total++;
            print_verdict();
        end
    end
endmodule
